// ===== src/qbp_defines.svh
// Constants for the quasi-bidirectional port pair
`ifndef QBP_DEFINES_SVH
`define QBP_DEFINES_SVH
`define QBP_RESET_LATCH     8'hFF
`define QBP_BOOST_TIME_NS   10
`define QBP_CLK_PERIOD_NS   5
`define QBP_BOOST_CYCLES    ((`QBP_BOOST_TIME_NS + `QBP_CLK_PERIOD_NS - 1) / `QBP_CLK_PERIOD_NS)
`define QBP_BIT_T2_PIN      0
`define QBP_BIT_T2_TRIG     1
`define QBP_BIT_SER_RX      2
`define QBP_BIT_SER_TX      3
`define QBP_BIT_IRQ_C       4
`define QBP_BIT_IRQ_D       5
`define QBP_BIT_IRQ_E       6
`define QBP_BIT_IRQ_F       7
`endif

// ===== src/qbp_pin.sv
// One quasi-bidirectional pin cell with its transition boost timer
`timescale 1ns/1ps
`include "qbp_defines.svh"
module qbp_pin #(
  parameter int BOOST_CYCLES = `QBP_BOOST_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Value to present and pad sense
  input  wire logic out_val,
  input  wire logic pad_in,
  // Pad controls
  output logic      pull_down_q,
  output logic      strong_up_q,
  output logic      pad_q
);
  localparam int CW = $clog2(BOOST_CYCLES + 1);
  logic          prev_q;
  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_q      <= 1'b1;
      pull_down_q <= 1'b0;
    end else begin
      prev_q      <= out_val;
      pull_down_q <= ~out_val;
    end
  end

  // Boost only on a 0 to 1 step; weak pull-up carries the level afterwards
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q       <= '0;
      strong_up_q <= 1'b0;
    end else if (!out_val) begin
      // A zero cuts the boost short, so the two strong drivers never fight
      cnt_q       <= '0;
      strong_up_q <= 1'b0;
    end else if (out_val && !prev_q) begin
      cnt_q       <= CW'(BOOST_CYCLES - 1);
      strong_up_q <= 1'b1;
    end else if (cnt_q != '0) begin
      cnt_q       <= cnt_q - 1'b1;
      strong_up_q <= 1'b1;
    end else begin
      strong_up_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pad_q <= 1'b1;
    end else begin
      pad_q <= pad_in;
    end
  end
endmodule

// ===== src/qbp_pkg.sv
// Types for the quasi-bidirectional port pair
package qbp_pkg;
  typedef enum logic [1:0] {
    QBP_MODE_PORT,
    QBP_MODE_ADDR,
    QBP_MODE_PAGE1,
    QBP_MODE_PAGE2
  } qbp_bus_mode_t;
endpackage

// ===== src/qbp_port_pair.sv
// Two quasi-bidirectional 8-bit ports with alternate functions
`timescale 1ns/1ps
`include "qbp_defines.svh"
module qbp_port_pair #(
  parameter int WIDTH        = 8,
  parameter int BOOST_CYCLES = `QBP_BOOST_CYCLES
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Software port latches
  input  wire logic             porta_wr,
  input  wire logic [WIDTH-1:0] porta_wdata,
  input  wire logic             portb_wr,
  input  wire logic [WIDTH-1:0] portb_wdata,
  // Pin levels seen by software
  output logic [WIDTH-1:0]      porta_pins,
  output logic [WIDTH-1:0]      portb_pins,
  // Port A pads
  input  wire logic [WIDTH-1:0] porta_pad_in,
  output logic [WIDTH-1:0]      porta_pull_down,
  output logic [WIDTH-1:0]      porta_strong_up,
  // Port B pads
  input  wire logic [WIDTH-1:0] portb_pad_in,
  output logic [WIDTH-1:0]      portb_pull_down,
  output logic [WIDTH-1:0]      portb_strong_up,
  // Timer 2 and second serial port
  input  wire logic             timer2_out_en,
  input  wire logic             timer2_out_val,
  output logic                  timer2_ext_pin,
  output logic                  timer2_capture_trigger,
  input  wire logic             serial_b_enable,
  input  wire logic             serial_b_tx_val,
  output logic                  serial_b_receive,
  // Edge interrupt pulses
  output logic                  ext_irq_c_rising,
  output logic                  ext_irq_d_falling,
  output logic                  ext_irq_e_rising,
  output logic                  ext_irq_f_falling,
  // External memory bus
  input  wire qbp_pkg::qbp_bus_mode_t bus_mode,
  input  wire logic             bus_active,
  input  wire logic             addr_phase,
  input  wire logic [15:0]      bus_addr,
  input  wire logic [7:0]       bus_wdata,
  input  wire logic             bus_write,
  output logic [7:0]            bus_rdata,
  output logic [7:0]            low_addr_out,
  output logic                  low_addr_valid
);
  // ----------------------------------------------------------------
  // Port latches
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] porta_latch_q;
  logic [WIDTH-1:0] portb_latch_q;
  logic [WIDTH-1:0] porta_val;
  logic [WIDTH-1:0] portb_val;
  logic [WIDTH-1:0] porta_sync;
  logic [WIDTH-1:0] portb_sync;

  always_ff @(posedge clk) begin
    if (srst) begin
      porta_latch_q <= `QBP_RESET_LATCH;
    end else if (porta_wr) begin
      porta_latch_q <= porta_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      portb_latch_q <= `QBP_RESET_LATCH;
    end else if (portb_wr) begin
      portb_latch_q <= portb_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Alternate drive of port A
  // ----------------------------------------------------------------
  // Alternate outputs AND with the latch, so a latch one keeps the pin usable
  always_comb begin
    porta_val = porta_latch_q;
    if (timer2_out_en) begin
      porta_val[`QBP_BIT_T2_PIN] = porta_latch_q[`QBP_BIT_T2_PIN] & timer2_out_val;
    end
    if (serial_b_enable) begin
      porta_val[`QBP_BIT_SER_TX] = porta_latch_q[`QBP_BIT_SER_TX] & serial_b_tx_val;
    end
  end

  // ----------------------------------------------------------------
  // Port B source: latch or external bus
  // ----------------------------------------------------------------
  // Port B belongs to the bus only in the three bus modes
  logic bus_owns_b;
  assign bus_owns_b = bus_active && (bus_mode != qbp_pkg::QBP_MODE_PORT);

  always_comb begin
    portb_val = portb_latch_q;
    if (bus_owns_b) begin
      case (bus_mode)
        qbp_pkg::QBP_MODE_ADDR:  portb_val = bus_addr[15:8];
        qbp_pkg::QBP_MODE_PAGE1: portb_val = addr_phase ? bus_addr[15:8] : bus_addr[7:0];
        qbp_pkg::QBP_MODE_PAGE2: portb_val = addr_phase ? bus_addr[15:8]
                                             : (bus_write ? bus_wdata : 8'hFF);
        default:                 portb_val = portb_latch_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  // Pull-down off on a one leaves only the weak pull-up once the boost ends, so outside drivers win
  for (genvar i = 0; i < WIDTH; i++) begin : g_pins
    qbp_pin #(.BOOST_CYCLES(BOOST_CYCLES)) u_pa (
      .clk         (clk),
      .srst        (srst),
      .out_val     (porta_val[i]),
      .pad_in      (porta_pad_in[i]),
      .pull_down_q (porta_pull_down[i]),
      .strong_up_q (porta_strong_up[i]),
      .pad_q       (porta_sync[i])
    );
    qbp_pin #(.BOOST_CYCLES(BOOST_CYCLES)) u_pb (
      .clk         (clk),
      .srst        (srst),
      .out_val     (portb_val[i]),
      .pad_in      (portb_pad_in[i]),
      .pull_down_q (portb_pull_down[i]),
      .strong_up_q (portb_strong_up[i]),
      .pad_q       (portb_sync[i])
    );
  end

  // ----------------------------------------------------------------
  // Pin levels returned to software
  // ----------------------------------------------------------------
  assign porta_pins = porta_sync;
  assign portb_pins = portb_sync;

  // ----------------------------------------------------------------
  // Alternate inputs and edge interrupts
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] porta_prev_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      porta_prev_q <= `QBP_RESET_LATCH;
    end else begin
      porta_prev_q <= porta_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timer2_ext_pin         <= 1'b1;
      timer2_capture_trigger <= 1'b1;
    end else begin
      timer2_ext_pin         <= porta_sync[`QBP_BIT_T2_PIN];
      timer2_capture_trigger <= porta_sync[`QBP_BIT_T2_TRIG];
    end
  end

  // Receive idles high while the second serial port is off, so it never sees a start bit
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_b_receive <= 1'b1;
    end else begin
      serial_b_receive <= porta_sync[`QBP_BIT_SER_RX] | ~serial_b_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_irq_c_rising  <= 1'b0;
      ext_irq_d_falling <= 1'b0;
      ext_irq_e_rising  <= 1'b0;
      ext_irq_f_falling <= 1'b0;
    end else begin
      ext_irq_c_rising  <= porta_sync[`QBP_BIT_IRQ_C] & ~porta_prev_q[`QBP_BIT_IRQ_C];
      ext_irq_d_falling <= ~porta_sync[`QBP_BIT_IRQ_D] & porta_prev_q[`QBP_BIT_IRQ_D];
      ext_irq_e_rising  <= porta_sync[`QBP_BIT_IRQ_E] & ~porta_prev_q[`QBP_BIT_IRQ_E];
      ext_irq_f_falling <= ~porta_sync[`QBP_BIT_IRQ_F] & porta_prev_q[`QBP_BIT_IRQ_F];
    end
  end

  // ----------------------------------------------------------------
  // Bus return data and low address for the zero port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_rdata <= 8'hFF;
    end else begin
      bus_rdata <= portb_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      low_addr_out   <= 8'h00;
      low_addr_valid <= 1'b0;
    end else begin
      low_addr_out   <= bus_addr[7:0];
      low_addr_valid <= bus_active && addr_phase && (bus_mode == qbp_pkg::QBP_MODE_ADDR);
    end
  end
endmodule

// ===== test/qbp_pad_model.sv
// Outside circuit on one port: weak pull-up plus optional low drivers
`timescale 1ns/1ps
module qbp_pad_model (
  // Device drive
  input  wire logic [7:0] pull_down,
  // Outside low drivers, set by the bench
  input  wire logic [7:0] ext_low,
  // Resolved pad
  output logic [7:0]      pad
);
  // The weak pull-up loses to any low driver, so a released pin never floats
  assign pad = ~(pull_down | ext_low);
endmodule

// ===== test/qbp_port_pair_sva.sv
// Concurrent checks on the port pair's top-level ports
`timescale 1ns/1ps
module qbp_port_pair_sva #(
  parameter int BOOST_CYCLES = 2
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Port pins
  input wire logic        porta_wr,
  input wire logic [7:0]  porta_wdata,
  input wire logic [7:0]  porta_pins,
  input wire logic [7:0]  porta_pull_down,
  input wire logic [7:0]  porta_strong_up,
  input wire logic [7:0]  portb_pull_down,
  input wire logic [7:0]  portb_strong_up,
  // Alternate functions
  input wire logic        timer2_ext_pin,
  input wire logic        timer2_capture_trigger,
  input wire logic        ext_irq_c_rising,
  input wire logic        ext_irq_f_falling,
  // External bus
  input wire qbp_pkg::qbp_bus_mode_t bus_mode,
  input wire logic        bus_active,
  input wire logic        addr_phase,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  low_addr_out,
  input wire logic        low_addr_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Length of the current strong pull-up run on bit 6
  logic [3:0] up_cnt_q;
  always_ff @(posedge clk) begin
    if (srst || !porta_strong_up[6]) begin
      up_cnt_q <= 4'h0;
    end else begin
      up_cnt_q <= up_cnt_q + 4'h1;
    end
  end
  chk_reset_quiet: assert property ($fell(srst) |->
    (porta_pull_down | porta_strong_up | portb_pull_down | portb_strong_up) == 8'h00) else $error("drive after reset");
  chk_low_drive: assert property (porta_wr |-> ##2 porta_pull_down[7:4] == ~$past(porta_wdata[7:4], 2))
    else $error("pull-down does not follow write");
  chk_low_holds: assert property ($fell(porta_pull_down[7]) |-> $past(porta_wr, 2) && $past(porta_wdata[7], 2))
    else $error("pull-down released without a one");
  chk_boost_start: assert property ($fell(porta_pull_down[6]) |-> porta_strong_up[6])
    else $error("no strong pull-up on release");
  chk_boost_len: assert property ($fell(porta_strong_up[6]) && !porta_pull_down[6] |-> up_cnt_q == BOOST_CYCLES)
    else $error("strong pull-up length wrong");
  chk_no_fight: assert property (((porta_pull_down & porta_strong_up) | (portb_pull_down & portb_strong_up)) == 8'h00)
    else $error("strong pull-up and pull-down both on");
  chk_t2_follow: assert property ({timer2_capture_trigger, timer2_ext_pin} == $past(porta_pins[1:0]))
    else $error("timer 2 inputs differ from pins");
  chk_irq_rise: assert property ($rose(porta_pins[4]) |=> ext_irq_c_rising ##1 !ext_irq_c_rising)
    else $error("rising edge interrupt missing");
  chk_irq_fall: assert property ($fell(porta_pins[7]) |=> ext_irq_f_falling)
    else $error("falling edge interrupt missing");
  chk_addr_high: assert property ((bus_active && bus_mode == qbp_pkg::QBP_MODE_ADDR && $stable(bus_addr)) [*3]
    |-> portb_pull_down == ~bus_addr[15:8]) else $error("upper address not driven");
  chk_low_addr: assert property (bus_active && bus_mode == qbp_pkg::QBP_MODE_ADDR && addr_phase
    |=> low_addr_valid && low_addr_out == $past(bus_addr[7:0])) else $error("low address wrong");
endmodule
bind qbp_port_pair qbp_port_pair_sva #(.BOOST_CYCLES(BOOST_CYCLES)) u_chk (.*);

// ===== test/qbp_port_pair_test.sv
// Self-checking bench for the port pair
`timescale 1ns/1ps
module qbp_port_pair_test;
  logic clk, srst, porta_wr, portb_wr, timer2_out_en, timer2_out_val, serial_b_enable, serial_b_tx_val;
  logic bus_active, addr_phase, bus_write, timer2_ext_pin, timer2_capture_trigger, serial_b_receive;
  logic ext_irq_c_rising, ext_irq_d_falling, ext_irq_e_rising, ext_irq_f_falling, low_addr_valid;
  logic [7:0] porta_wdata, portb_wdata, porta_pins, portb_pins, porta_pad_in, portb_pad_in, porta_pull_down;
  logic [7:0] porta_strong_up, portb_pull_down, portb_strong_up, bus_wdata, bus_rdata, low_addr_out;
  logic [7:0] ext_a, ext_b, d, e, p, n, x;
  logic [15:0] bus_addr;
  qbp_pkg::qbp_bus_mode_t bus_mode;
  int err_count, n_tests, seed, i;
  qbp_port_pair #(.WIDTH(8), .BOOST_CYCLES(2)) u_dut (.*);
  qbp_pad_model u_pad_a (.pull_down(porta_pull_down), .ext_low(ext_a), .pad(porta_pad_in));
  qbp_pad_model u_pad_b (.pull_down(portb_pull_down), .ext_low(ext_b), .pad(portb_pad_in));
  task automatic step(input int cnt);
    repeat (cnt) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Port B level the bus should present for a mode and phase
  function automatic logic [7:0] exp_b(qbp_pkg::qbp_bus_mode_t m, logic ph, logic [15:0] a, logic [7:0] wd, logic w);
    case (m)
      qbp_pkg::QBP_MODE_PAGE1: return ph ? a[15:8] : a[7:0];
      qbp_pkg::QBP_MODE_PAGE2: return ph ? a[15:8] : (w ? wd : 8'hFF);
      default: return a[15:8];
    endcase
  endfunction
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    srst = 1'b1;
    {porta_wr, portb_wr, timer2_out_en, timer2_out_val, serial_b_enable, serial_b_tx_val} = 6'h00;
    {bus_active, addr_phase, bus_write, bus_addr} = 19'h00000;
    {porta_wdata, portb_wdata, bus_wdata, ext_a, ext_b, d} = 48'h000000000000;
    bus_mode = qbp_pkg::QBP_MODE_PORT;
    {err_count, n_tests, seed} = {32'h0, 32'h0, 32'h00002BB9};
    step(3);
    srst = 1'b0;
    step(1);
    chk(porta_pins, 8'hFF);
    chk(portb_pins, 8'hFF);
    // Back-to-back writes, the second one wins
    for (i = 0; i < 24; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      {porta_wr, portb_wr, porta_wdata, portb_wdata} = {2'h3, ~d, ~d};
      step(1);
      {porta_wdata, portb_wdata} = {d, d};
      step(1);
      {porta_wr, portb_wr} = 2'h0;
      step(3);
      chk(porta_pull_down, 8'(~d));
      chk(portb_pull_down, 8'(~d));
      chk(porta_strong_up | portb_strong_up, 8'h00);
      chk({porta_pins, portb_pins}, {d, d});
    end
    // Releasing the low bits gives each of them two cycles of strong pull-up
    {porta_wr, porta_wdata} = {1'b1, 8'hFF};
    step(1);
    porta_wr = 1'b0;
    step(1);
    chk(porta_strong_up, 8'(~d));
    step(1);
    chk(porta_strong_up, 8'(~d));
    step(1);
    chk({porta_strong_up, porta_pull_down}, 16'h0000);
    step(1);
    p = 8'hFF;
    // Outside drivers pull released pins low
    for (i = 0; i < 32; i++) begin
      e = 8'($random(seed));
      ext_a = e;
      n = ~e;
      step(2);
      chk(porta_pins, n);
      chk({ext_irq_c_rising, ext_irq_d_falling}, {~p[4] & n[4], p[5] & ~n[5]});
      chk({ext_irq_e_rising, ext_irq_f_falling}, {~p[6] & n[6], p[7] & ~n[7]});
      chk({timer2_ext_pin, timer2_capture_trigger}, {n[0], n[1]});
      p = n;
    end
    {timer2_out_en, serial_b_enable} = 2'h3;
    for (i = 0; i < 2; i++) begin
      {timer2_out_val, serial_b_tx_val, ext_a} = {i[0], i[0], i[0] ? 8'h00 : 8'h04};
      step(4);
      chk({porta_pull_down[0], porta_pull_down[3], serial_b_receive}, {~i[0], ~i[0], i[0]});
    end
    {timer2_out_en, serial_b_enable} = 2'h0;
    // Bus owns port B; a latch zero written meanwhile shows once the bus lets go
    {portb_wr, portb_wdata, bus_active} = {1'b1, 8'h00, 1'b1};
    for (i = 0; i < 12; i++) begin
      bus_mode = qbp_pkg::qbp_bus_mode_t'(2'(1 + i % 3));
      {addr_phase, bus_write} = {i[1], i[2]};
      {bus_addr, bus_wdata, ext_b} = 32'($random(seed));
      x = exp_b(bus_mode, addr_phase, bus_addr, bus_wdata, bus_write);
      step(4);
      chk(portb_pull_down, 8'(~x));
      chk(bus_rdata, x & ~ext_b);
      chk({low_addr_valid, low_addr_out}, {bus_mode == qbp_pkg::QBP_MODE_ADDR && addr_phase, bus_addr[7:0]});
    end
    {portb_wr, bus_active, ext_b} = 10'h000;
    step(4);
    chk(portb_pull_down, 8'hFF);
    {porta_wr, porta_wdata} = {1'b1, 8'h00};
    step(1);
    porta_wr = 1'b0;
    step(3);
    srst = 1'b1;
    step(3);
    srst = 1'b0;
    step(1);
    chk({porta_pull_down, porta_pins}, 16'h00FF);
    wrap_up();
  end
endmodule
